// ===== via_ctrl.sv
// Interrupt acceptance, priority and nesting control with APB registers
//
// How it works
// [RULE_01] Source eligible when pending set, mask clear
// [RULE_02] Maskable vectoring only while global enable set
// [RULE_03] Request to branch takes 9 to 16 clocks
// [RULE_04] Highest programmed level wins, then default order
// [RULE_05] Unaccepted requests stay pending until acceptable
// [RULE_06] Accept: push status, push PC, vector, branch
// [RULE_07] Maskable handler returns by maskable return
// [RULE_08] Trap pushes status, PC, clears enable, vector 7E
// [RULE_09] Trap always taken, ignores enable and masks
// [RULE_10] Trap handler leaves only by trap return
// [RULE_11] Nesting needs enable set again by software
// [RULE_12] Nesting only for strictly higher priority; code also lets level 0 nest in level 0
// [RULE_13] After return, one main instruction before acceptance
// [RULE_14] In-service level code 11 means idle
// [RULE_15] Two-bit field: 00 highest, 11 lowest
// [RULE_16] During trap any level accepted if enabled
// [RULE_17] Hold instructions and flag writes defer acceptance
// [RULE_18] Accepted nonzero field minus one becomes level
// [RULE_19] Reset status word is 06H
// [RULE_20] Lower source index wins equal-level ties
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps

module via_ctrl #(
    parameter int NSRC = 8                            // Maskable sources
) (
    input  wire logic                  pclk,          // CPU clock
    input  wire logic                  presetn,       // Async reset, low
    input  wire via_pkg::via_apb_req_t apb_req,       // APB request
    output logic                       pready,        // APB ready
    output logic [31:0]                prdata,        // APB read data
    output logic                       pslverr,       // APB error
    input  wire logic [NSRC-1:0]       src_event,     // Request pulses
    input  wire logic                  instr_done,    // Instruction ends
    input  wire via_pkg::via_instr_t   instr_class,   // Its class
    input  wire logic [7:0]            psw_wdata,     // Status word value
    output logic                       seq_busy,      // Stall sequencer
    output logic                       seq_push_psw,  // Push status pulse
    output logic                       seq_push_pc,   // Push PC pulse
    output logic                       seq_branch,    // Branch pulse
    output via_pkg::via_take_t         seq_take,      // Taken service
    output logic [7:0]                 program_status_word, // Status
    output logic                       global_irq_enable,   // Enable flag
    output logic                       trap_active          // In trap
);

    typedef enum logic [1:0] {ST_RUN, ST_STACK} via_state_t;

    logic [7:0]             psw_r;
    logic [NSRC-1:0]        pend_r;
    logic [NSRC-1:0]        mask_r;
    logic [NSRC-1:0]        prio_lo_r;
    logic [NSRC-1:0]        prio_hi_r;
    logic                   trap_r;
    logic                   wr_hold_r;
    via_state_t             state_r;
    logic [via_pkg::CNT_W-1:0] cnt_r;
    via_pkg::via_take_t     take_r;

    // Combinational decisions
    logic                   ie;
    logic [1:0]             isp;
    logic                   found;
    logic [$clog2(NSRC)-1:0] best_idx;
    logic [1:0]             best_lvl;
    logic                   boundary;
    logic                   held;
    logic                   take_trap;
    logic                   take_mask;
    logic [NSRC-1:0]        pend_clr;

    // APB decode
    logic                   apb_setup;
    logic                   apb_wr;
    logic                   flag_wr;

    assign ie = psw_r[via_pkg::PSW_IE_BIT];
    assign isp = {psw_r[via_pkg::PSW_IN_SERVICE_LEVEL_BIT1_BIT], psw_r[via_pkg::PSW_IN_SERVICE_LEVEL_BIT0_BIT]};
    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign flag_wr = apb_wr && (apb_req.paddr <= via_pkg::OFS_PRIO_HI);

    // Pick eligible source: lowest level, lower index on ties
    always_comb begin
        found = 1'b0;
        best_idx = '0;
        best_lvl = 2'h3;
        for (int i = 0; i < NSRC; i++) begin
            if (pend_r[i] && !mask_r[i]) begin             // see [RULE_01]
                if (!found || {prio_hi_r[i], prio_lo_r[i]} < best_lvl) begin
                    found = 1'b1;                          // see [RULE_04]
                    best_idx = i[$clog2(NSRC)-1:0];        // see [RULE_20]
                    best_lvl = {prio_hi_r[i], prio_lo_r[i]}; // see [RULE_15]
                end
            end
        end
    end

    // Acceptance only at an instruction boundary; a maskable one also not under hold
    assign boundary = instr_done && (state_r == ST_RUN);
    assign held = wr_hold_r                                // see [RULE_17]
                || instr_class == via_pkg::INSTR_HOLD
                || instr_class == via_pkg::INSTR_PSW_WRITE
                || instr_class == via_pkg::INSTR_MASKABLE_RETURN // see [RULE_13]
                || instr_class == via_pkg::INSTR_TRAP_RETURN
                || instr_class == via_pkg::INSTR_ENABLE_IRQ
                || instr_class == via_pkg::INSTR_DISABLE_IRQ;
    assign take_trap = boundary
                && instr_class == via_pkg::INSTR_TRAP;     // see [RULE_09]
    // Level compare: isp code doubles as highest level still admitted
    assign take_mask = boundary && !take_trap && !held && found
                && ie                                      // see [RULE_02] [RULE_11]
                && (trap_r || best_lvl <= isp);            // see [RULE_12] [RULE_14] [RULE_16]

    always_comb begin
        pend_clr = '0;
        if (take_mask) begin
            pend_clr[best_idx] = 1'b1;
        end
    end

    // Pending flags: a new event beats any clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= '0;
        end else if (apb_wr && apb_req.paddr == via_pkg::OFS_PENDING) begin
            pend_r <= apb_req.pwdata[NSRC-1:0] | src_event;
        end else begin
            pend_r <= (pend_r & ~pend_clr) | src_event;   // see [RULE_05]
        end
    end

    // Mask and priority flags, reset to all masked, lowest level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r    <= '1;
            prio_lo_r <= '1;
            prio_hi_r <= '1;
        end else if (apb_wr) begin
            case (apb_req.paddr)
                via_pkg::OFS_MASK: mask_r <= apb_req.pwdata[NSRC-1:0];
                via_pkg::OFS_PRIO_LO: prio_lo_r <= apb_req.pwdata[NSRC-1:0];
                via_pkg::OFS_PRIO_HI: prio_hi_r <= apb_req.pwdata[NSRC-1:0];
                default: ;
            endcase
        end
    end

    // Flag or status writes block the boundary of the writing instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_hold_r <= 1'b0;
        end else if (flag_wr) begin
            wr_hold_r <= 1'b1;                             // see [RULE_17]
        end else if (instr_done) begin
            wr_hold_r <= 1'b0;
        end
    end

    // Status word: acceptance outranks instructions in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psw_r <= via_pkg::PSW_RESET;                   // see [RULE_19]
        end else if (take_trap) begin
            psw_r[via_pkg::PSW_IE_BIT] <= 1'b0;            // see [RULE_08]
        end else if (take_mask) begin
            psw_r[via_pkg::PSW_IE_BIT] <= 1'b0;            // see [RULE_06]
            // Level 0 and 1 both map to code 00
            if (best_lvl != 2'h0) begin                    // see [RULE_18]
                psw_r[via_pkg::PSW_IN_SERVICE_LEVEL_BIT1_BIT] <= best_lvl[1] & best_lvl[0];
                psw_r[via_pkg::PSW_IN_SERVICE_LEVEL_BIT0_BIT] <= best_lvl[1] & ~best_lvl[0];
            end else begin
                psw_r[via_pkg::PSW_IN_SERVICE_LEVEL_BIT1_BIT] <= 1'b0;
                psw_r[via_pkg::PSW_IN_SERVICE_LEVEL_BIT0_BIT] <= 1'b0;
            end
        end else if (apb_wr && apb_req.paddr == via_pkg::OFS_PSW) begin
            psw_r <= apb_req.pwdata[7:0];
        end else if (instr_done) begin
            case (instr_class)
                via_pkg::INSTR_ENABLE_IRQ:  psw_r[via_pkg::PSW_IE_BIT] <= 1'b1;
                via_pkg::INSTR_DISABLE_IRQ: psw_r[via_pkg::PSW_IE_BIT] <= 1'b0;
                via_pkg::INSTR_PSW_WRITE,
                via_pkg::INSTR_MASKABLE_RETURN,            // see [RULE_07]
                via_pkg::INSTR_TRAP_RETURN: psw_r <= psw_wdata; // see [RULE_10]
                default: ;
            endcase
        end
    end

    // Trap service marker, dropped by the trap return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_r <= 1'b0;
        end else if (take_trap) begin
            trap_r <= 1'b1;
        end else if (instr_done
                     && instr_class == via_pkg::INSTR_TRAP_RETURN) begin
            trap_r <= 1'b0;
        end
    end

    // Stacking sequence; its length fixes the least latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_RUN;
            cnt_r   <= '0;
            take_r  <= '0;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (take_trap || take_mask) begin
                        state_r <= ST_STACK;
                        cnt_r   <= '0;
                        take_r.is_trap   <= take_trap;
                        take_r.saved_psw <= psw_r;
                        take_r.vec_addr  <= take_trap ? via_pkg::TRAP_VECTOR
                            : via_pkg::VEC_TABLE_BASE
                              + 20'({best_idx, 1'b0});
                    end
                end
                ST_STACK: begin
                    cnt_r <= cnt_r + 1'b1;                 // see [RULE_03]
                    if (cnt_r == via_pkg::CNT_W'(via_pkg::ACCEPT_CYCLES - 2)) begin
                        state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // Sequencer strobes: status first, then PC, branch last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_busy     <= 1'b0;
            seq_push_psw <= 1'b0;
            seq_push_pc  <= 1'b0;
            seq_branch   <= 1'b0;
        end else begin
            seq_busy     <= (state_r == ST_RUN) ? (take_trap || take_mask)
                : (cnt_r != via_pkg::CNT_W'(via_pkg::ACCEPT_CYCLES - 2));
            seq_push_psw <= state_r == ST_RUN && (take_trap || take_mask);
            seq_push_pc  <= state_r == ST_STACK && cnt_r == '0; // see [RULE_06]
            seq_branch   <= state_r == ST_STACK
                && cnt_r == via_pkg::CNT_W'(via_pkg::ACCEPT_CYCLES - 2);
        end
    end

    // Mirrors of internal state, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_status_word <= via_pkg::PSW_RESET;
            global_irq_enable   <= 1'b0;
            trap_active         <= 1'b0;
        end else begin
            program_status_word <= psw_r;
            global_irq_enable   <= psw_r[via_pkg::PSW_IE_BIT];
            trap_active         <= trap_r;
        end
    end

    // Taken service straight from its stacking register, so the
    // sequencer already sees it in the cycle of the status push
    assign seq_take = take_r;

    // APB slave: data staged in setup, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (apb_setup) begin
                case (apb_req.paddr)
                    via_pkg::OFS_PSW:     prdata <= {24'h0, psw_r};
                    via_pkg::OFS_PENDING: prdata <= 32'(pend_r);
                    via_pkg::OFS_MASK:    prdata <= 32'(mask_r);
                    via_pkg::OFS_PRIO_LO: prdata <= 32'(prio_lo_r);
                    via_pkg::OFS_PRIO_HI: prdata <= 32'(prio_hi_r);
                    via_pkg::OFS_STATUS:  prdata <= {29'h0, trap_r,
                        state_r == ST_STACK, wr_hold_r};
                    default:              pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule // via_ctrl

// ===== via_pkg.sv
// Shared constants and types for the vectored interrupt acceptance block
package via_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFS_PSW      = 8'h00;
    localparam logic [7:0] OFS_PENDING  = 8'h04;
    localparam logic [7:0] OFS_MASK     = 8'h08;
    localparam logic [7:0] OFS_PRIO_LO  = 8'h0c;
    localparam logic [7:0] OFS_PRIO_HI  = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;

    // Status word field positions
    localparam int PSW_IE_BIT   = 7;
    localparam int PSW_IN_SERVICE_LEVEL_BIT1_BIT = 2;
    localparam int PSW_IN_SERVICE_LEVEL_BIT0_BIT = 1;

    // Reset values
    localparam logic [7:0] PSW_RESET  = 8'h06;
    localparam logic [1:0] ISP_IDLE   = 2'h3;

    // Vector table
    localparam logic [19:0] TRAP_VECTOR     = 20'h0007e;
    localparam logic [19:0] VEC_TABLE_BASE  = 20'h00004;

    // Acceptance latency in CPU clocks
    localparam int MIN_LAT_CLKS   = 9;
    localparam int MAX_LAT_CLKS   = 16;
    localparam int ACCEPT_CYCLES  = MIN_LAT_CLKS - 1;
    localparam int CNT_W          = 4;

    // Class of the instruction that the sequencer reports as completed
    typedef enum logic [2:0] {
        INSTR_NORMAL,
        INSTR_HOLD,
        INSTR_PSW_WRITE,
        INSTR_TRAP,
        INSTR_MASKABLE_RETURN,
        INSTR_TRAP_RETURN,
        INSTR_ENABLE_IRQ,
        INSTR_DISABLE_IRQ
    } via_instr_t;

    // Information handed to the sequencer when a service is taken
    typedef struct packed {
        logic        is_trap;
        logic [19:0] vec_addr;
        logic [7:0]  saved_psw;
    } via_take_t;

    // APB request group
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } via_apb_req_t;

endpackage

// ===== via_seq_model.sv
// Behavioural instruction sequencer facing the acceptance block
`timescale 1ns/1ps

module via_seq_model (
    input  wire logic                pclk,         // CPU clock
    input  wire logic                presetn,      // Async reset, low
    input  wire logic                go,           // Issue one instruction
    input  wire via_pkg::via_instr_t cls,          // Class to issue
    input  wire logic                seq_busy,     // Block is stacking
    input  wire logic                seq_push_psw, // Status push pulse
    input  wire via_pkg::via_take_t  seq_take,     // Taken service
    output logic                     instr_done,   // Instruction ends
    output via_pkg::via_instr_t      instr_class,  // Its class
    output logic [7:0]               psw_wdata     // Popped status word
);
    logic [8:0] stk [0:7];  // Trap marker and saved status word
    logic [2:0] sp;         // Stack depth
    logic       ret;        // Bench asks for a return
    logic [8:0] top;        // Innermost service

    assign ret = cls inside {via_pkg::INSTR_MASKABLE_RETURN,
                             via_pkg::INSTR_TRAP_RETURN};
    assign top = stk[sp - 3'd1];

    // Gap cycle after each report, so a take shows busy before the next
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_done  <= 1'b0;
            instr_class <= via_pkg::INSTR_NORMAL;
            psw_wdata   <= 8'h00;
            sp          <= 3'h0;
        end else begin
            instr_done <= go && !instr_done && !seq_busy;
            if (go && !instr_done && !seq_busy) begin
                // Return kind follows the service it ends
                if (!ret) begin
                    instr_class <= cls;
                    psw_wdata   <= 8'h86;  // Enabled, no service active
                end else if (top[8]) begin
                    instr_class <= via_pkg::INSTR_TRAP_RETURN;
                    psw_wdata   <= top[7:0];
                end else begin
                    instr_class <= via_pkg::INSTR_MASKABLE_RETURN;
                    psw_wdata   <= top[7:0];
                end
                if (ret) begin
                    sp <= sp - 3'd1;
                end
            end else begin
                psw_wdata <= ~psw_wdata;  // Stale value inverted on every cycle without a report
            end
            if (seq_push_psw) begin
                stk[sp] <= {seq_take.is_trap, seq_take.saved_psw};
                sp      <= sp + 3'd1;
            end
        end
    end
endmodule // via_seq_model

// ===== via_ctrl_checker.sv
// Concurrent checks on the acceptance block's ports
`timescale 1ns/1ps

module via_ctrl_checker #(
    parameter int NSRC = 8                            // Maskable sources
) (
    input wire logic                  pclk,           // CPU clock
    input wire logic                  presetn,        // Async reset, low
    input wire via_pkg::via_apb_req_t apb_req,        // APB request
    input wire logic                  pready,         // APB ready
    input wire logic [31:0]           prdata,         // APB read data
    input wire logic                  pslverr,        // APB error
    input wire logic [NSRC-1:0]       src_event,      // Request pulses
    input wire logic                  instr_done,     // Instruction ends
    input wire via_pkg::via_instr_t   instr_class,    // Its class
    input wire logic [7:0]            psw_wdata,      // Status value
    input wire logic                  seq_busy,       // Stall
    input wire logic                  seq_push_psw,   // Push status
    input wire logic                  seq_push_pc,    // Push PC
    input wire logic                  seq_branch,     // Branch
    input wire via_pkg::via_take_t    seq_take,       // Taken service
    input wire logic [7:0]            program_status_word, // Status
    input wire logic                  global_irq_enable,   // Enable
    input wire logic                  trap_active          // In trap
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Stacking steps: status word, then counter
    sequence push_pair_s;
        seq_push_psw ##1 seq_push_pc;
    endsequence
    // Busy covers the walk and drops in the branch cycle
    sequence busy_walk_s;
        seq_busy [*7] ##1 !seq_busy;
    endsequence

    push_order_a: assert property (
        seq_push_psw |-> push_pair_s) else $error("push order broken");
    busy_span_a: assert property (
        seq_push_psw |-> busy_walk_s) else $error("busy span wrong");
    branch_time_a: assert property (
        seq_push_psw |-> !seq_branch [*7] ##1 seq_branch)
        else $error("branch not at fixed latency");
    ie_cleared_a: assert property (
        seq_branch |-> !global_irq_enable) else $error("enable not cleared");
    trap_vector_a: assert property (
        seq_push_psw && seq_take.is_trap |->
        seq_take.vec_addr == via_pkg::TRAP_VECTOR) else $error("trap vector");
    ie_needed_a: assert property (
        seq_push_psw && !seq_take.is_trap |-> global_irq_enable)
        else $error("maskable taken while disabled");
    take_cause_a: assert property (
        seq_push_psw |-> $past(instr_done) && !$past(seq_busy))
        else $error("take without instruction end");
    hold_defer_a: assert property (
        instr_done && !seq_busy && !(instr_class inside
        {via_pkg::INSTR_NORMAL, via_pkg::INSTR_TRAP}) |=> !seq_push_psw)
        else $error("take after hold instruction");
    trap_always_a: assert property (
        instr_done && !seq_busy && instr_class == via_pkg::INSTR_TRAP
        |=> seq_push_psw && seq_take.is_trap) else $error("trap not taken");
    reset_word_a: assert property (
        !$past(presetn) |-> program_status_word == via_pkg::PSW_RESET
        && !global_irq_enable) else $error("status word reset value");
endmodule // via_ctrl_checker

bind via_ctrl via_ctrl_checker #(.NSRC(NSRC)) i_via_ctrl_checker (.*);

// ===== tb_via_ctrl.sv
// Self-checking bench for the interrupt acceptance block
`timescale 1ns/1ps

module tb_via_ctrl;
    logic                  pclk = 1'b0;             // 50 ns period
    logic                  presetn;                 // Reset, low
    via_pkg::via_apb_req_t apb_req = '0;            // APB master
    logic [7:0]            src_event = 8'h00;       // Request pulses
    logic                  go = 1'b0;               // Issue instruction
    via_pkg::via_instr_t   cls = via_pkg::INSTR_NORMAL; // Its class
    logic                  pready, pslverr, instr_done, seq_busy, er;
    logic                  seq_push_psw, seq_push_pc, seq_branch;
    logic                  global_irq_enable, trap_active;
    logic [31:0]           prdata, rd;
    logic [7:0]            psw_wdata, program_status_word;
    via_pkg::via_instr_t   instr_class;
    via_pkg::via_take_t    seq_take;
    int                    num_errors = 0;
    int                    n_checks = 0;

    via_ctrl #(.NSRC(8)) i_via_ctrl (.*);
    via_seq_model i_via_seq_model (.*);

    // Free-running clock
    always #25 pclk = ~pclk;

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask

    task automatic hang;
        num_errors++;
        stop_test;
    endtask

    // APB transfer; a fresh edge first, so a release never meets a setup
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 50) hang;
        rd = prdata;
        er = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // One instruction; t says whether a service must be taken at its end
    task automatic step(input via_pkg::via_instr_t c, input logic t,
                        input logic [19:0] v);
        int n;
        go <= 1'b1;
        cls <= c;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (instr_done === 1'b1) break;
        end
        go <= 1'b0;
        if (n == 50) hang;
        @(posedge pclk);
        chk(32'(seq_push_psw), 32'(t));
        if (t) begin
            chk(32'(seq_take.vec_addr), 32'(v));
            chk(32'(seq_take.is_trap), 32'(v == 20'h7e));
            repeat (7) @(posedge pclk);
            chk(32'(seq_branch), 32'h1);
        end
    endtask

    task automatic pulse(input logic [7:0] m);
        src_event <= m;
        @(posedge pclk);
        src_event <= 8'h00;
    endtask

    task automatic t_reset;
        apb(1'b0, via_pkg::OFS_PSW, 32'h0);
        chk(rd, 32'h06);
        apb(1'b0, via_pkg::OFS_MASK, 32'h0);
        chk(rd, 32'hff);
        apb(1'b0, 8'h18, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        $display("test reset done");
    endtask

    // Status mirrors trail the core by a cycle, so checks wait one edge
    task automatic t_single;
        apb(1'b1, via_pkg::OFS_MASK, 32'hfb);
        pulse(8'h04);
        step(via_pkg::INSTR_NORMAL, 1'b0, 20'h0);
        step(via_pkg::INSTR_NORMAL, 1'b0, 20'h0);
        step(via_pkg::INSTR_ENABLE_IRQ, 1'b0, 20'h0);
        step(via_pkg::INSTR_NORMAL, 1'b1, 20'h8);
        chk(32'(seq_take.saved_psw), 32'h86);
        chk(32'(program_status_word), 32'h04);
        step(via_pkg::INSTR_MASKABLE_RETURN, 1'b0, 20'h0);
        @(posedge pclk);
        chk(32'(program_status_word), 32'h86);
        $display("test single done");
    endtask

    task automatic t_nest;
        apb(1'b1, via_pkg::OFS_PRIO_LO, 32'hfc);
        apb(1'b1, via_pkg::OFS_PRIO_HI, 32'hb6);
        apb(1'b1, via_pkg::OFS_MASK, 32'hb4);
        pulse(8'h4e);
        step(via_pkg::INSTR_NORMAL, 1'b0, 20'h0);
        step(via_pkg::INSTR_NORMAL, 1'b1, 20'ha);
        chk(32'(program_status_word), 32'h00);
        step(via_pkg::INSTR_ENABLE_IRQ, 1'b0, 20'h0);
        step(via_pkg::INSTR_NORMAL, 1'b0, 20'h0);
        pulse(8'h01);
        step(via_pkg::INSTR_NORMAL, 1'b1, 20'h4);
        step(via_pkg::INSTR_MASKABLE_RETURN, 1'b0, 20'h0);
        step(via_pkg::INSTR_TRAP, 1'b1, 20'h7e);
        chk(32'(trap_active), 32'h1);
        step(via_pkg::INSTR_NORMAL, 1'b0, 20'h0);
        step(via_pkg::INSTR_ENABLE_IRQ, 1'b0, 20'h0);
        step(via_pkg::INSTR_NORMAL, 1'b1, 20'h10);
        step(via_pkg::INSTR_MASKABLE_RETURN, 1'b0, 20'h0);
        step(via_pkg::INSTR_NORMAL, 1'b1, 20'h6);
        step(via_pkg::INSTR_MASKABLE_RETURN, 1'b0, 20'h0);
        step(via_pkg::INSTR_MASKABLE_RETURN, 1'b0, 20'h0);
        @(posedge pclk);
        chk(32'(trap_active), 32'h0);
        step(via_pkg::INSTR_MASKABLE_RETURN, 1'b0, 20'h0);
        @(posedge pclk);
        chk(32'(program_status_word), 32'h86);
        $display("test nest done");
    endtask

    task automatic t_hold;
        step(via_pkg::INSTR_NORMAL, 1'b0, 20'h0);
        apb(1'b1, via_pkg::OFS_MASK, 32'hfb);
        step(via_pkg::INSTR_NORMAL, 1'b0, 20'h0);
        step(via_pkg::INSTR_HOLD, 1'b0, 20'h0);
        step(via_pkg::INSTR_PSW_WRITE, 1'b0, 20'h0);
        step(via_pkg::INSTR_DISABLE_IRQ, 1'b0, 20'h0);
        step(via_pkg::INSTR_NORMAL, 1'b0, 20'h0);
        step(via_pkg::INSTR_ENABLE_IRQ, 1'b0, 20'h0);
        step(via_pkg::INSTR_NORMAL, 1'b1, 20'h8);
        $display("test hold done");
    endtask

    // Reset, then each scenario in turn
    initial begin
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_single;
        t_nest;
        t_hold;
        stop_test;
    end
endmodule // tb_via_ctrl
